// >>> verilog/ptimer_pkg.sv
// Constants and types for the 10-bit periodic timer
`default_nettype none
package ptimer_pkg;
	localparam int CNT_W = 10;
	localparam logic [9:0] CNT_MAX = 10'h3FF;
	localparam logic [9:0] CNT_ZERO = 10'h000;
	localparam logic [9:0] CNT_ONE = 10'h001;
	// Avalon word indexes
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_DUTY = 3'h1;
	localparam logic [2:0] ADDR_PERIOD = 3'h2;
	localparam logic [2:0] ADDR_COUNT = 3'h3;
	localparam logic [2:0] ADDR_FLAGS = 3'h4;
	// Control word field positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_MODE_HI = 2;
	localparam int CTRL_ACT_LO = 3;
	localparam int CTRL_ACT_HI = 4;
	localparam int CTRL_CAP_SRC = 5;
	localparam int CTRL_CLR_SRC = 6;
	localparam int CTRL_INIT_LVL = 7;
	localparam int CTRL_POL = 8;
	// Flag word field positions
	localparam int FLAG_A = 0;
	localparam int FLAG_P = 1;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_PULSE   = 2'b10,
		MODE_TIMER   = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		ACT_00 = 2'b00,
		ACT_01 = 2'b01,
		ACT_10 = 2'b10,
		ACT_11 = 2'b11
	} act_e;
endpackage : ptimer_pkg
`default_nettype wire

// >>> verilog/periodic_timer_pulse_capture.sv
// Periodic timer with single-pulse output and capture input modes
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`default_nettype none
// How it works
// R01: Software picks pulse mode as 10, action 11
// R02: Run bit rising edge starts the pulse
// R03: External pin edge sets run bit in pulse mode
// R04: Run rising starts counter and leading edge
// R05: Clearing run bit ends the pulse
// R06: Compare A match clears run, ends pulse
// R07: Compare A match in pulse mode sets flag
// R08: Pulse counter zeroed only at run rising
// R09: Pulse mode ignores period and clear select
// R10: Software picks capture mode as 01
// R11: Source select picks capture or clock pin
// R12: Action field picks rising, falling or both
// R13: Capture counter starts at run rising edge
// R14: Active edge copies count to duty, sets flag
// R15: Capture counter runs until run bit falls
// R16: Period match zeroes counter, sets flag
// R17: Action 11 disables capture, counter still runs
// R18: Period zero gives full counter range
// R19: Capture mode drives no output function
// R20: Captures happen even if pin drives out
// R21: Counter is 10 bits, tops at 3FF
// R22: Separate flags for compare A and P
// R23: Run rising loads initial output level
// R24: Pins synchronised, edges from sampled pairs
// R25: Pulse output idle between pulses
module periodic_timer_pulse_capture
	import ptimer_pkg::*;
(
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RST_N,
	input  wire logic [2:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	input  wire logic        I_EXT_CLOCK_PIN,
	input  wire logic        I_CAPTURE_IN_PIN,
	output logic             O_TIMER_OUT,
	output logic             O_TIMER_OUT_EN,
	output logic             O_COMPARE_A_FLAG,
	output logic             O_COMPARE_P_FLAG
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic              run_bit;
		mode_e             mode;
		act_e              out_action;
		logic              capture_source_sel;
		logic              clear_source_sel;
		logic              out_initial_level;
		logic              out_polarity;
		logic [CNT_W-1:0]  duty_compare_value;
		logic [CNT_W-1:0]  period_compare_value;
		logic [CNT_W-1:0]  count;
		logic              compare_a_flag;
		logic              compare_p_flag;
		logic              out_level;
		logic              pin;
		logic              ext_meta;
		logic              ext_sync;
		logic              ext_prev;
		logic              cap_meta;
		logic              cap_sync;
		logic              cap_prev;
		logic              ack;
		logic [31:0]       rdata;
	} state_s;

	localparam state_s STATE_RESET = '{
		run_bit:              1'b0,
		mode:                 MODE_COMPARE,
		out_action:           ACT_00,
		capture_source_sel:   1'b0,
		clear_source_sel:     1'b0,
		out_initial_level:    1'b0,
		out_polarity:         1'b0,
		duty_compare_value:   CNT_ZERO,
		period_compare_value: CNT_ZERO,
		count:                CNT_ZERO,
		compare_a_flag:       1'b0,
		compare_p_flag:       1'b0,
		out_level:            1'b0,
		pin:                  1'b0,
		ext_meta:             1'b0,
		ext_sync:             1'b0,
		ext_prev:             1'b0,
		cap_meta:             1'b0,
		cap_sync:             1'b0,
		cap_prev:             1'b0,
		ack:                  1'b0,
		rdata:                RDATA_ZERO
	};

	state_s state;
	state_s next_state;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Edge qualifier shared by both capture sources
	function automatic logic edge_hit(input act_e act, input logic now,
			input logic prev);
		case (act)
			ACT_00:  edge_hit = now & ~prev;
			ACT_01:  edge_hit = ~now & prev;
			ACT_10:  edge_hit = now ^ prev;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// Word address decode shared by every register write
	function automatic logic addr_is(input logic [2:0] addr,
			input logic [2:0] want);
		addr_is = (addr == want);
	endfunction : addr_is

	// Counter-sized values sit in the low bits of a bus word
	function automatic logic [31:0] word_of(input logic [CNT_W-1:0] v);
		word_of = RDATA_ZERO;
		word_of[CNT_W-1:0] = v;
	endfunction : word_of

	function automatic logic [31:0] ctrl_word(input state_s s);
		ctrl_word = RDATA_ZERO;
		ctrl_word[CTRL_RUN] = s.run_bit;
		ctrl_word[CTRL_MODE_HI:CTRL_MODE_LO] = s.mode;
		ctrl_word[CTRL_ACT_HI:CTRL_ACT_LO] = s.out_action;
		ctrl_word[CTRL_CAP_SRC] = s.capture_source_sel;
		ctrl_word[CTRL_CLR_SRC] = s.clear_source_sel;
		ctrl_word[CTRL_INIT_LVL] = s.out_initial_level;
		ctrl_word[CTRL_POL] = s.out_polarity;
	endfunction : ctrl_word

	////////////////////////////////////////////////////////////////////////
	// Next state

	logic             req;
	logic             wr_go;
	logic             run_cmd;
	logic             run_rise;
	logic             ext_rise;
	logic             sel_now;
	logic             sel_prev;
	logic             cap_hit;
	logic [CNT_W-1:0] count_inc;
	logic             a_match;
	logic             p_match;
	logic             pwm_lvl;
	// Write strobes, flag events and the config the pin follows
	logic             wr_ctrl;
	logic             wr_duty;
	logic             wr_period;
	logic             wr_flags;
	logic             set_a;
	logic             set_p;
	logic             clr_a;
	logic             clr_p;
	logic             cfg_init;
	logic             cfg_pol;
	mode_e            cfg_mode;
	act_e             cfg_act;

	always_comb begin
		next_state = state;
		req = I_AVS_READ | I_AVS_WRITE;
		wr_go = I_AVS_WRITE & state.ack;
		// One strobe per writable word, only on the completing cycle
		wr_ctrl = wr_go && addr_is(I_AVS_ADDRESS, ADDR_CTRL);
		wr_duty = wr_go && addr_is(I_AVS_ADDRESS, ADDR_DUTY);
		wr_period = wr_go && addr_is(I_AVS_ADDRESS, ADDR_PERIOD);
		wr_flags = wr_go && addr_is(I_AVS_ADDRESS, ADDR_FLAGS);
		set_a = 1'b0;
		set_p = 1'b0;
		// R24: two flops, then edge pairs
		next_state.ext_meta = I_EXT_CLOCK_PIN;
		next_state.ext_sync = state.ext_meta;
		next_state.ext_prev = state.ext_sync;
		next_state.cap_meta = I_CAPTURE_IN_PIN;
		next_state.cap_sync = state.cap_meta;
		next_state.cap_prev = state.cap_sync;
		ext_rise = state.ext_sync & ~state.ext_prev;

		// Bus: one wait cycle, read data sampled on the first
		next_state.ack = req & ~state.ack;
		if (req && !state.ack) begin
			case (I_AVS_ADDRESS)
				ADDR_CTRL:   next_state.rdata = ctrl_word(state);
				ADDR_DUTY:   next_state.rdata =
					word_of(state.duty_compare_value);
				ADDR_PERIOD: next_state.rdata =
					word_of(state.period_compare_value);
				ADDR_COUNT:  next_state.rdata = word_of(state.count);
				ADDR_FLAGS:  next_state.rdata = {30'h00000000,
					state.compare_p_flag, state.compare_a_flag};
				default:     next_state.rdata = RDATA_ZERO;
			endcase
		end

		run_cmd = state.run_bit;
		if (wr_ctrl) begin
			run_cmd = I_AVS_WRITEDATA[CTRL_RUN];
			next_state.mode =
				mode_e'(I_AVS_WRITEDATA[CTRL_MODE_HI:CTRL_MODE_LO]);
			next_state.out_action =
				act_e'(I_AVS_WRITEDATA[CTRL_ACT_HI:CTRL_ACT_LO]);
			next_state.capture_source_sel = I_AVS_WRITEDATA[CTRL_CAP_SRC];
			next_state.clear_source_sel = I_AVS_WRITEDATA[CTRL_CLR_SRC];
			next_state.out_initial_level = I_AVS_WRITEDATA[CTRL_INIT_LVL];
			next_state.out_polarity = I_AVS_WRITEDATA[CTRL_POL];
		end
		if (wr_duty) begin
			next_state.duty_compare_value = I_AVS_WRITEDATA[CNT_W-1:0];
		end
		if (wr_period) begin
			next_state.period_compare_value = I_AVS_WRITEDATA[CNT_W-1:0];
		end

		// R03: ext pin edge arms the pulse
		if (state.mode == MODE_PULSE && ext_rise) begin
			run_cmd = 1'b1;
		end

		// R21: 10-bit count, wraps past 3FF
		count_inc = state.count + CNT_ONE;
		a_match = state.run_bit && count_inc == state.duty_compare_value;
		// R18: period zero matches only after 3FF wraps
		p_match = state.run_bit && count_inc == state.period_compare_value;

		// R06: compare A ends the pulse
		if (state.mode == MODE_PULSE && a_match) begin
			run_cmd = 1'b0;
		end
		run_rise = run_cmd & ~state.run_bit;
		next_state.run_bit = run_cmd;

		cap_hit = 1'b0;
		if (run_rise) begin
			// R02: sw or pin rising starts it
			// R04: counter starts, leading edge
			// R08: zero only at run rising
			// R13: capture counter starts here
			next_state.count = CNT_ZERO;
			// R23: initial output level
			next_state.out_level = next_state.out_initial_level;
		end else if (state.run_bit) begin
			case (state.mode)
				MODE_PULSE: begin
					// R09: period and clear select unused
					// Hardware stop on A beats a racing sw write
					next_state.count = count_inc;
					if (a_match) begin
						// R07: A match raises request
						set_a = 1'b1;
					end
				end
				MODE_CAPTURE: begin
					// R15: free run until run falls
					// R16: period match wraps, flags
					if (p_match) begin
						next_state.count = CNT_ZERO;
						set_p = 1'b1;
					end else begin
						next_state.count = count_inc;
					end
				end
				default: begin
					if (state.clear_source_sel && state.mode != MODE_PULSE
							&& state.duty_compare_value != CNT_ZERO && a_match) begin
						next_state.count = CNT_ZERO;
					end else if (!state.clear_source_sel && p_match) begin
						next_state.count = CNT_ZERO;
					end else begin
						next_state.count = count_inc;
					end
					if (a_match && state.duty_compare_value != CNT_ZERO) begin
						set_a = 1'b1;
						case (state.out_action)
							ACT_01:  next_state.out_level = 1'b0;
							ACT_10:  next_state.out_level = 1'b1;
							ACT_11:  next_state.out_level = ~state.out_level;
							default: next_state.out_level = state.out_level;
						endcase
					end
					if (p_match && !state.clear_source_sel) begin
						set_p = 1'b1;
					end
				end
			endcase
		end

		// R11: source select picks the pin
		sel_now = state.capture_source_sel ? state.ext_sync : state.cap_sync;
		sel_prev = state.capture_source_sel ? state.ext_prev : state.cap_prev;
		// R12: edge kind from action field
		// R17: action 11 never captures
		// R20: no check of pin direction
		if (state.mode == MODE_CAPTURE) begin
			cap_hit = edge_hit(state.out_action, sel_now, sel_prev);
		end
		if (cap_hit) begin
			// R14: latch count, raise request
			next_state.duty_compare_value = state.count;
			set_a = 1'b1;
		end

		// R22: separate flags, set beats clear
		// Clear is masked by a same-cycle event so none is lost
		clr_a = wr_flags && I_AVS_WRITEDATA[FLAG_A];
		clr_p = wr_flags && I_AVS_WRITEDATA[FLAG_P];
		next_state.compare_a_flag = (state.compare_a_flag & ~clr_a) | set_a;
		next_state.compare_p_flag = (state.compare_p_flag & ~clr_p) | set_p;

		// Pin follows the config written this cycle, so a start
		// write that also changes level or polarity is not a cycle late
		cfg_init = next_state.out_initial_level;
		cfg_pol = next_state.out_polarity;
		cfg_mode = next_state.mode;
		cfg_act = next_state.out_action;
		pwm_lvl = (state.count < state.duty_compare_value)
			? cfg_init : ~cfg_init;
		case (cfg_mode)
			MODE_PULSE: begin
				if (cfg_act == ACT_11) begin
					// R05: pulse ends with run low
					// R25: idle level until next start
					next_state.pin = (next_state.run_bit
						? cfg_init : ~cfg_init) ^ cfg_pol;
				end else begin
					case (cfg_act)
						ACT_00:  next_state.pin = cfg_pol;
						ACT_01:  next_state.pin = ~cfg_pol;
						default: next_state.pin = pwm_lvl ^ cfg_pol;
					endcase
				end
			end
			// R19: capture drives no output
			MODE_CAPTURE: next_state.pin = 1'b0;
			MODE_TIMER:   next_state.pin = 1'b0;
			default:      next_state.pin = next_state.out_level;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			state <= STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Waitrequest combinational so the master sees it in the request cycle
	assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~state.ack;
	assign O_AVS_READDATA = state.rdata;
	assign O_TIMER_OUT = state.pin;
	assign O_TIMER_OUT_EN = (state.mode == MODE_COMPARE)
		|| (state.mode == MODE_PULSE);
	assign O_COMPARE_A_FLAG = state.compare_a_flag;
	assign O_COMPARE_P_FLAG = state.compare_p_flag;

endmodule : periodic_timer_pulse_capture
`default_nettype wire

// >>> tb/ptimer_assertions.sv
// Port assertions for the periodic timer
`default_nettype none
module ptimer_assertions
	import ptimer_pkg::*;
(
	input wire logic        I_CLK_SYS,
	input wire logic        I_RST_N,
	input wire logic [2:0]  I_AVS_ADDRESS,
	input wire logic        I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic        O_AVS_WAITREQUEST,
	input wire logic        I_EXT_CLOCK_PIN,
	input wire logic        O_TIMER_OUT,
	input wire logic        O_TIMER_OUT_EN,
	input wire logic        O_COMPARE_A_FLAG,
	input wire logic        O_COMPARE_P_FLAG
);
	logic [8:0] ctrl;
	logic       ctl_wr;
	logic       flg_wr;
	logic       pulse;
	logic       capt;
	logic       act_lvl;
	// Run bit is stale here: hardware clears it
	assign ctl_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST
		&& I_AVS_ADDRESS == ADDR_CTRL;
	assign flg_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST
		&& I_AVS_ADDRESS == ADDR_FLAGS;
	assign pulse = ctrl[4:1] == 4'hE;
	assign capt = ctrl[2:1] == MODE_CAPTURE;
	assign act_lvl = ctrl[7] ^ ctrl[8];
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			ctrl <= 9'h000;
		end else if (ctl_wr) begin
			ctrl <= I_AVS_WRITEDATA[8:0];
		end
	end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	////////////////////////////////////////////////////////////////
	a_pulse_lead_level: assert property (
		ctl_wr && I_AVS_WRITEDATA[4:0] == 5'h1D |-> ##2 O_TIMER_OUT == act_lvl)
		else $error("pulse leading level wrong");
	a_stop_goes_idle: assert property (
		ctl_wr && I_AVS_WRITEDATA[4:0] == 5'h1C
		|-> ##[1:2] O_TIMER_OUT == !act_lvl)
		else $error("software stop left output active");
	a_ext_starts_pulse: assert property (
		pulse && $rose(I_EXT_CLOCK_PIN) |-> ##[2:6] O_TIMER_OUT == act_lvl)
		else $error("external edge did not start pulse");
	a_match_ends_pulse: assert property (
		pulse && $rose(O_COMPARE_A_FLAG) |-> ##[0:1] O_TIMER_OUT == !act_lvl)
		else $error("compare match did not end pulse");
	a_flag_a_sticky: assert property (
		O_COMPARE_A_FLAG && !(flg_wr && I_AVS_WRITEDATA[FLAG_A])
		|=> O_COMPARE_A_FLAG) else $error("flag A dropped uncleared");
	a_flag_p_sticky: assert property (
		O_COMPARE_P_FLAG && !(flg_wr && I_AVS_WRITEDATA[FLAG_P])
		|=> O_COMPARE_P_FLAG) else $error("flag P dropped uncleared");
	a_pulse_ignores_period: assert property (
		pulse |=> !$rose(O_COMPARE_P_FLAG))
		else $error("period match acted in pulse mode");
	a_capture_no_drive: assert property (
		capt |-> !O_TIMER_OUT_EN) else $error("capture mode drives pin");
	a_capture_out_low: assert property (
		capt ##1 capt |-> !O_TIMER_OUT) else $error("capture output not low");
	c_pulse_end: cover property (pulse && $rose(O_COMPARE_A_FLAG));
	c_capture: cover property (capt && $rose(O_COMPARE_A_FLAG));
	c_wrap: cover property (capt && $rose(O_COMPARE_P_FLAG));
endmodule : ptimer_assertions

bind periodic_timer_pulse_capture ptimer_assertions chk (.I_CLK_SYS,
	.I_RST_N, .I_AVS_ADDRESS, .I_AVS_WRITE, .I_AVS_WRITEDATA,
	.O_AVS_WAITREQUEST, .I_EXT_CLOCK_PIN, .O_TIMER_OUT, .O_TIMER_OUT_EN,
	.O_COMPARE_A_FLAG, .O_COMPARE_P_FLAG);
`default_nettype wire

// >>> tb/ptimer_pins.sv
// Model of the external trigger and capture pins
`default_nettype none
module ptimer_pins (
	input  wire logic i_clk,
	output var  logic o_ext_clock_pin,
	output var  logic o_capture_in_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_ext_clock_pin = 1'b0;
		o_capture_in_pin = 1'b0;
	end
	// Slow edges: waits out the two-flop synchroniser
	task automatic drive(input logic ext, input logic lvl);
		@(posedge i_clk);
		if (ext) begin
			o_ext_clock_pin <= lvl;
		end else begin
			o_capture_in_pin <= lvl;
		end
		repeat (6) @(posedge i_clk);
	endtask : drive
endmodule : ptimer_pins
`default_nettype wire

// >>> tb/periodic_timer_pulse_capture_bench.sv
// Self-checking bench for the periodic timer
`default_nettype none
module periodic_timer_pulse_capture_bench
	import ptimer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;
	logic        rst_n;
	logic [2:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitreq;
	wire logic   ext_pin;
	wire logic   cap_pin;
	logic        tout;
	logic        tout_en;
	logic        flag_a;
	logic        flag_p;
	logic [31:0] q;
	logic [31:0] t;
	int          n;
	int          miscompares;
	int          checks_done;
	periodic_timer_pulse_capture dut (.I_CLK_SYS(clk), .I_RST_N(rst_n),
		.I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
		.I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(waitreq), .I_EXT_CLOCK_PIN(ext_pin),
		.I_CAPTURE_IN_PIN(cap_pin), .O_TIMER_OUT(tout),
		.O_TIMER_OUT_EN(tout_en), .O_COMPARE_A_FLAG(flag_a),
		.O_COMPARE_P_FLAG(flag_p));
	ptimer_pins pins (.i_clk(clk), .o_ext_clock_pin(ext_pin),
		.o_capture_in_pin(cap_pin));
	////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (waitreq !== 1'b0 && k < 50);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (k >= 50) miscompares++;
	endtask : bus
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Samples start with the level the write edge launched
	task automatic measure(input logic lvl);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			if (tout === lvl) n++;
		end
	endtask : measure
	task automatic conclude();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 3'h0;
		wdata = 32'h0000_0000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		bus(1, 3'h5, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++) begin
			bus(0, i[2:0], 32'h0);
			chk(q, 32'h0);
		end
		chk(tout_en, 1'b1);
		// Period and clear select set to show they are ignored
		bus(1, ADDR_PERIOD, 32'h3);
		for (int i = 0; i < 4; i++) begin
			bus(1, ADDR_FLAGS, 32'h3);
			bus(1, ADDR_DUTY, 32'h5 + i);
			bus(1, ADDR_CTRL, {i[1:0], 7'h5D});
			measure(i[0] ^ i[1]);
			chk(n, 5 + i);
			bus(0, ADDR_CTRL, 32'h0);
			chk(q, {i[1:0], 7'h5C});
			bus(0, ADDR_COUNT, 32'h0);
			chk(q, 5 + i);
			bus(0, ADDR_FLAGS, 32'h0);
			chk(q, 32'h1);
		end
		bus(1, ADDR_FLAGS, 32'h3);
		bus(1, ADDR_DUTY, 32'h0);
		bus(1, ADDR_CTRL, 32'h1D);
		repeat (5) @(posedge clk);
		chk(tout, 1'b0);
		bus(1, ADDR_CTRL, 32'h1C);
		repeat (3) @(posedge clk);
		chk(tout, 1'b1);
		bus(0, ADDR_FLAGS, 32'h0);
		chk(q, 32'h0);
		bus(1, ADDR_DUTY, 32'h6);
		pins.drive(1, 1);
		repeat (20) @(posedge clk);
		bus(0, ADDR_COUNT, 32'h0);
		chk(q, 32'h6);
		chk(flag_a, 1'b1);
		chk(tout, 1'b1);
		pins.drive(1, 0);
		bus(1, ADDR_PERIOD, 32'h40);
		for (int a = 0; a < 4; a++) begin
			bus(1, ADDR_CTRL, {a[1:0], 3'h3});
			@(posedge clk);
			chk(tout_en, 1'b0);
			bus(1, ADDR_FLAGS, 32'h3);
			pins.drive(0, 1);
			bus(0, ADDR_FLAGS, 32'h0);
			chk(q[0], a == 0 || a == 2);
			bus(1, ADDR_FLAGS, 32'h3);
			pins.drive(0, 0);
			bus(0, ADDR_FLAGS, 32'h0);
			chk(q[0], a == 1 || a == 2);
			bus(0, ADDR_DUTY, 32'h0);
			chk(q < 32'h40, 1'b1);
		end
		bus(1, ADDR_CTRL, 32'h23);
		bus(1, ADDR_FLAGS, 32'h3);
		pins.drive(0, 1);
		chk(flag_a, 1'b0);
		pins.drive(1, 1);
		chk(flag_a, 1'b1);
		repeat (70) @(posedge clk);
		chk(flag_p, 1'b1);
		bus(1, ADDR_PERIOD, 32'h0);
		bus(1, ADDR_CTRL, 32'h3);
		bus(1, ADDR_FLAGS, 32'h3);
		repeat (300) @(posedge clk);
		bus(0, ADDR_COUNT, 32'h0);
		chk(q > 32'h100, 1'b1);
		chk(flag_p, 1'b0);
		bus(1, ADDR_CTRL, 32'h2);
		bus(0, ADDR_COUNT, 32'h0);
		t = q;
		repeat (10) @(posedge clk);
		bus(0, ADDR_COUNT, 32'h0);
		chk(q, t);
		conclude();
	end
endmodule : periodic_timer_pulse_capture_bench
`default_nettype wire
